// ---- hpc_pkg.sv ----
// hpc_pkg: constants and carrier types of the hub port phy configuration bank
package hpc_pkg;

    // ****************************************
    // register indices (byte address is four times the index)
    // ****************************************
    localparam int unsigned   HPC_ADDR_W      = 12;
    localparam int unsigned   HPC_IDX_W       = 10;
    localparam logic [9:0]    HPC_IDX_CTRL    = 10'h0f0;
    localparam logic [9:0]    HPC_IDX_STATUS  = 10'h0f1;
    localparam logic [9:0]    HPC_IDX_BOOST   = 10'h0f8;
    localparam logic [9:0]    HPC_IDX_SWAP    = 10'h0fa;
    localparam logic [9:0]    HPC_IDX_REMAP   = 10'h0fb;

    // ****************************************
    // field positions and masks
    // ****************************************
    localparam int unsigned   HPC_P1_BOOST_LSB = 0;
    localparam int unsigned   HPC_P2_BOOST_LSB = 4;
    localparam int unsigned   HPC_P1_REMAP_LSB = 0;
    localparam int unsigned   HPC_P2_REMAP_LSB = 4;
    localparam int unsigned   HPC_CTRL_HUB     = 0;
    localparam int unsigned   HPC_CTRL_REMAP   = 1;
    localparam int unsigned   HPC_ST_LOG1_LSB  = 0;
    localparam int unsigned   HPC_ST_LOG2_LSB  = 2;
    localparam int unsigned   HPC_ST_CNT_LSB   = 4;
    localparam logic [7:0]    HPC_BOOST_MASK   = 8'h77;
    localparam logic [7:0]    HPC_SWAP_MASK    = 8'h0f;
    localparam logic [7:0]    HPC_CTRL_MASK    = 8'h03;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0]    HPC_BOOST_RST    = 8'h00;
    localparam logic [7:0]    HPC_SWAP_RST     = 8'h00;
    localparam logic [7:0]    HPC_REMAP_RST    = 8'h21;
    localparam logic [7:0]    HPC_CTRL_RST     = 8'h01;
    localparam logic [1:0]    HPC_PORT_COUNT   = 2'h3;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [3:0]            pstrb;
        logic [HPC_ADDR_W-1:0] paddr;
        logic [31:0]           pwdata;
    } hpc_apb_req_t;

    // bit 0 upstream port, bits 1..3 downstream ports 1..3
    typedef struct packed {
        logic [3:0]            p;
        logic [3:0]            n;
    } hpc_pair_t;

    typedef struct packed {
        logic [7:0]            boost;
        logic [7:0]            swap;
        logic [7:0]            remap;
        logic [7:0]            ctrl;
        logic [31:0]           rdata;
        hpc_pair_t             pinOut;
        hpc_pair_t             pinOeN;
        hpc_pair_t             sync1;
        hpc_pair_t             sync2;
        hpc_pair_t             funcIn;
        logic [1:0]            log1;
        logic [1:0]            log2;
        logic [1:0]            count;
        logic signed [5:0]     pct1;
        logic signed [5:0]     pct2;
    } hpc_state_t;

endpackage

// ---- hpc_port_phy_config_regs.sv ----
// hpc_port_phy_config_regs: apb register bank for drive boost, pin swap and port remap
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// - bits 6:4 set port 2 boost
// - bits 2:0 set port 1 boost
// - boost codes decode to signed percentages
// - swap bits: upstream, ports 1..3
// - swap 0: plus to positive pin
// - swap 1: plus to negative pin
// - swap acts only in hub mode
// - remap register resets to 0x21
// - remap applies only when enabled
// - bits 7:4 give port 2 logical number
// - codes 1..3 map; reserved act as disabled
// - bits 3:0 give port 1 logical number
// - report only enabled downstream port count
module hpc_port_phy_config_regs
(
    input  wire  logic                      mclk,
    input  wire  logic                      nrst,
    input  wire  hpc_pkg::hpc_apb_req_t     apb,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire  hpc_pkg::hpc_pair_t        funcOut,
    input  wire  hpc_pkg::hpc_pair_t        funcOeN,
    output hpc_pkg::hpc_pair_t              funcIn,
    input  wire  hpc_pkg::hpc_pair_t        pinIn,
    output hpc_pkg::hpc_pair_t              pinOut,
    output hpc_pkg::hpc_pair_t              pinOeN,
    output logic [2:0]                      port1Boost,
    output logic [2:0]                      port2Boost,
    output logic signed [5:0]               port1BoostPct,
    output logic signed [5:0]               port2BoostPct,
    output logic [1:0]                      port1Logical,
    output logic [1:0]                      port2Logical,
    output logic [1:0]                      reportedPortCount,
    output logic                            hubMode,
    output logic                            remapEnable
);
    import hpc_pkg::*;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic signed [5:0] boostPct(input logic [2:0] code);
        logic signed [5:0] pct;
        unique case (code)
            3'h0: pct = 6'sd0;
            3'h1: pct = -6'sd5;
            3'h2: pct = 6'sd10;
            3'h3: pct = 6'sd5;
            3'h4: pct = 6'sd20;
            3'h5: pct = 6'sd15;
            3'h6: pct = 6'sd30;
            3'h7: pct = 6'sd25;
        endcase
        return pct;
    endfunction

    // reserved codes behave as disabled
    function automatic logic [1:0] remapCode(input logic [3:0] code);
        return (code > 4'h3) ? 2'h0 : code[1:0];
    endfunction

    hpc_state_t                 state;
    hpc_state_t                 next_state;
    logic                       setup;
    logic                       access;
    logic                       wrLow;
    logic [HPC_IDX_W-1:0]       idx;
    logic                       hit;
    logic [3:0]                 effSwap;
    logic [3:0]                 outP;
    logic [3:0]                 outN;
    logic [3:0]                 oeP;
    logic [3:0]                 oeN;
    logic [3:0]                 inP;
    logic [3:0]                 inN;
    logic [2:0]                 code1;
    logic [2:0]                 code2;
    logic [1:0]                 map1;
    logic [1:0]                 map2;

    // ****************************************
    // apb decode
    // ****************************************
    assign setup  = apb.psel & ~apb.penable;
    assign access = apb.psel & apb.penable;
    assign wrLow  = access & apb.pwrite & apb.pstrb[0];
    assign idx    = apb.paddr[HPC_ADDR_W-1:2];

    always_comb
    begin
        hit = 1'b0;
        if (apb.paddr[1:0] == 2'h0)
        begin
            hit = (idx == HPC_IDX_CTRL) || (idx == HPC_IDX_STATUS) ||
                  (idx == HPC_IDX_BOOST) || (idx == HPC_IDX_SWAP) ||
                  (idx == HPC_IDX_REMAP);
        end
    end

    // zero wait states: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;
    assign prdata  = state.rdata;

    // ****************************************
    // per-port line swap
    // ****************************************
    // swap follows the stored bit at once; software must not flip it mid-packet
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_port
            assign effSwap[i] = state.swap[i] & state.ctrl[HPC_CTRL_HUB];
            assign outP[i] = effSwap[i] ? funcOut.n[i] : funcOut.p[i];
            assign outN[i] = effSwap[i] ? funcOut.p[i] : funcOut.n[i];
            assign oeP[i]  = effSwap[i] ? funcOeN.n[i] : funcOeN.p[i];
            assign oeN[i]  = effSwap[i] ? funcOeN.p[i] : funcOeN.n[i];
            assign inP[i]  = effSwap[i] ? state.sync2.n[i] : state.sync2.p[i];
            assign inN[i]  = effSwap[i] ? state.sync2.p[i] : state.sync2.n[i];
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_state = state;
        if (wrLow && hit)
        begin
            unique case (idx)
                HPC_IDX_CTRL:   next_state.ctrl  = apb.pwdata[7:0] & HPC_CTRL_MASK;
                HPC_IDX_BOOST:  next_state.boost = apb.pwdata[7:0] & HPC_BOOST_MASK;
                HPC_IDX_SWAP:   next_state.swap  = apb.pwdata[7:0] & HPC_SWAP_MASK;
                HPC_IDX_REMAP:  next_state.remap = apb.pwdata[7:0];
                default:        next_state.ctrl  = state.ctrl;
            endcase
        end
        if (setup)
        begin
            next_state.rdata = 32'h0;
            // unaligned or unmapped reads return zero alongside the error
            if (hit)
            begin
                unique case (idx)
                    HPC_IDX_CTRL:   next_state.rdata[7:0] = state.ctrl;
                    HPC_IDX_BOOST:  next_state.rdata[7:0] = state.boost;
                    HPC_IDX_SWAP:   next_state.rdata[7:0] = state.swap;
                    HPC_IDX_REMAP:  next_state.rdata[7:0] = state.remap;
                    HPC_IDX_STATUS:
                    begin
                        next_state.rdata[HPC_ST_LOG1_LSB +: 2] = state.log1;
                        next_state.rdata[HPC_ST_LOG2_LSB +: 2] = state.log2;
                        next_state.rdata[HPC_ST_CNT_LSB +: 2]  = state.count;
                    end
                    default:        next_state.rdata = 32'h0;
                endcase
            end
        end
        // pin inputs pass two flip-flops before the swap mux reads them
        next_state.sync1    = pinIn;
        next_state.sync2    = state.sync1;
        next_state.pinOut   = '{p: outP, n: outN};
        next_state.pinOeN   = '{p: oeP, n: oeN};
        next_state.funcIn   = '{p: inP, n: inN};
        next_state.pct1     = boostPct(code1);
        next_state.pct2     = boostPct(code2);
        if (state.ctrl[HPC_CTRL_REMAP])
        begin
            next_state.log1  = map1;
            next_state.log2  = map2;
            // port 3 keeps its logical number; only enabled ports count
            next_state.count = 2'({1'b0, map1 != 2'h0} + {1'b0, map2 != 2'h0} + 2'h1);
        end
        else
        begin
            next_state.log1  = 2'h1;
            next_state.log2  = 2'h2;
            next_state.count = HPC_PORT_COUNT;
        end
    end

    assign code1 = state.boost[HPC_P1_BOOST_LSB +: 3];
    assign code2 = state.boost[HPC_P2_BOOST_LSB +: 3];
    assign map1  = remapCode(state.remap[HPC_P1_REMAP_LSB +: 4]);
    assign map2  = remapCode(state.remap[HPC_P2_REMAP_LSB +: 4]);

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= '{boost:  HPC_BOOST_RST,
                       swap:   HPC_SWAP_RST,
                       remap:  HPC_REMAP_RST,
                       ctrl:   HPC_CTRL_RST,
                       pinOeN: '1,
                       log1:   2'h1,
                       log2:   2'h2,
                       count:  HPC_PORT_COUNT,
                       default: '0};
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pinOut            = state.pinOut;
    assign pinOeN            = state.pinOeN;
    assign funcIn            = state.funcIn;
    assign port1Boost        = code1;
    assign port2Boost        = code2;
    assign port1BoostPct     = state.pct1;
    assign port2BoostPct     = state.pct2;
    assign port1Logical      = state.log1;
    assign port2Logical      = state.log2;
    assign reportedPortCount = state.count;
    assign hubMode           = state.ctrl[HPC_CTRL_HUB];
    assign remapEnable       = state.ctrl[HPC_CTRL_REMAP];

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    reserved_zero_a: assert property (
        ((state.boost & ~HPC_BOOST_MASK) == 8'h0) && ((state.swap & ~HPC_SWAP_MASK) == 8'h0))
        else $error("reserved bits not zero");

    p2_boost_a: assert property (
        wrLow && (idx == HPC_IDX_BOOST) && (apb.paddr[1:0] == 2'h0)
        |=> port2Boost == $past(apb.pwdata[6:4]))
        else $error("port 2 boost not written");

    p1_boost_a: assert property (
        wrLow && (idx == HPC_IDX_BOOST) && (apb.paddr[1:0] == 2'h0)
        |=> ##1 port1BoostPct == boostPct($past(apb.pwdata[2:0], 2)))
        else $error("port 1 boost decode wrong");

    boost_decode_a: assert property (
        (port2Boost == 3'h6) ##1 (port2Boost == 3'h6) |-> port2BoostPct == 6'sd30)
        else $error("boost code 110 not thirty percent");

    swap_on_a: assert property (
        hubMode && state.swap[1] |=> pinOut.p[1] == $past(funcOut.n[1]))
        else $error("swapped port drives wrong line");

    swap_off_a: assert property (
        !hubMode |=> (pinOut.p == $past(funcOut.p)) && (pinOut.n == $past(funcOut.n)))
        else $error("swap active outside hub mode");

    remap_off_a: assert property (
        !remapEnable ##1 !remapEnable |-> port1Logical == 2'h1 && port2Logical == 2'h2)
        else $error("mapping applied while disabled");

    remap_res_a: assert property (
        remapEnable && (state.remap[3:0] > 4'h3) |=> port1Logical == 2'h0)
        else $error("reserved remap code not disabled");

    port_count_a: assert property (
        remapEnable && (state.remap[7:4] > 4'h3) && (state.remap[3:0] == 4'h3) ##1 remapEnable
        |-> reportedPortCount == 2'h2)
        else $error("enabled port count wrong");

    swap_plain_a: assert property (
        hubMode && !state.swap[2]
        |=> (pinOut.p[2] == $past(funcOut.p[2])) && (pinOut.n[2] == $past(funcOut.n[2])))
        else $error("unswapped port drives wrong line");

    swap_rx_a: assert property (
        hubMode && state.swap[3] |=> funcIn.p[3] == $past(state.sync2.n[3]))
        else $error("swapped port receives wrong line");

    remap_p2_a: assert property (
        remapEnable && (state.remap[7:4] == 4'h1) |=> port2Logical == 2'h1)
        else $error("port 2 code 0001 not logical 1");

    remap_p1_a: assert property (
        remapEnable && (state.remap[3:0] == 4'h2) |=> port1Logical == 2'h2)
        else $error("port 1 code 0010 not logical 2");

    status_count_a: assert property (
        setup && (idx == HPC_IDX_STATUS) && (apb.paddr[1:0] == 2'h0)
        |=> prdata[HPC_ST_CNT_LSB +: 2] == $past(reportedPortCount))
        else $error("status port count wrong");

    read_upper_a: assert property (
        setup |=> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");

endmodule

// ---- testbench.sv ----
// testbench: self-checking bench of the hub port phy configuration bank
`timescale 1ns/1ps
module testbench;
    import hpc_pkg::*;
    logic               mclk;
    logic               nrst;
    hpc_apb_req_t       apb;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    hpc_pair_t          funcOut;
    hpc_pair_t          funcOeN;
    hpc_pair_t          funcIn;
    hpc_pair_t          pinIn;
    hpc_pair_t          pinOut;
    hpc_pair_t          pinOeN;
    logic [2:0]         port1Boost;
    logic [2:0]         port2Boost;
    logic signed [5:0]  port1BoostPct;
    logic signed [5:0]  port2BoostPct;
    logic [1:0]         port1Logical;
    logic [1:0]         port2Logical;
    logic [1:0]         reportedPortCount;
    logic               hubMode;
    logic               remapEnable;
    int                 numErrors;
    int                 nCompared;
    logic [31:0]        seed;
    logic [31:0]        rdVal;
    logic               rdErr;
    int                 pctTable [8] = '{0, -5, 10, 5, 20, 15, 30, 25};

    hpc_port_phy_config_regs dut (.mclk(mclk), .nrst(nrst), .apb(apb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .funcOut(funcOut), .funcOeN(funcOeN), .funcIn(funcIn), .pinIn(pinIn),
        .pinOut(pinOut), .pinOeN(pinOeN), .port1Boost(port1Boost), .port2Boost(port2Boost),
        .port1BoostPct(port1BoostPct), .port2BoostPct(port2BoostPct), .port1Logical(port1Logical),
        .port2Logical(port2Logical), .reportedPortCount(reportedPortCount), .hubMode(hubMode),
        .remapEnable(remapEnable));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // model of the line exchange: a set bit crosses plus and minus
    function automatic hpc_pair_t swapLines(input hpc_pair_t x, input logic [3:0] e);
        return '{p: (x.p & ~e) | (x.n & e), n: (x.n & ~e) | (x.p & e)};
    endfunction

    function automatic logic [1:0] logOf(input int c);
        return (c >= 1 && c <= 3) ? 2'(c) : 2'h0;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        nCompared++;
        if (got !== exp)
        begin
            numErrors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic stopTest();
        if (numErrors == 0 && nCompared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one apb transfer; an idle cycle follows so the request is never assigned twice in one step
    // the wait has no limit of its own: only the watchdog ends a hung transfer
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, pstrb: 4'hf, paddr: a, pwdata: d};
        @(posedge mclk);
        apb.penable <= 1'b1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'b1);
        rdVal = prdata;
        rdErr = pslverr;
        apb <= '0;
        @(posedge mclk);
    endtask

    // ****************************************
    // clock, reset and watchdog
    // ****************************************
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        numErrors++;
        stopTest();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [31:0] r;
        logic [3:0]  eff;
        int          l1;
        int          l2;
        int          cnt;
        apb = '0;
        funcOut = '0;
        funcOeN = '1;
        pinIn = '0;
        nrst = 1'b0;
        numErrors = 0;
        nCompared = 0;
        seed = 32'd62;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        xfer(1'b0, 12'h3e0, 32'h0);
        check(rdVal, 32'h00, "boost reset");
        xfer(1'b0, 12'h3e8, 32'h0);
        check(rdVal, 32'h00, "swap reset");
        xfer(1'b0, 12'h3ec, 32'h0);
        check(rdVal, 32'h21, "remap reset");
        check({port2Logical, port1Logical, reportedPortCount}, 32'h27, "reset mapping");
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, 12'h3e0, {24'h0, 1'b1, 3'(i), 1'b1, 3'(7 - i)});
            repeat (2) @(posedge mclk);
            check(port2Boost, 32'(i), "port 2 boost");
            check(port1Boost, 32'(7 - i), "port 1 boost");
            check(port2BoostPct, 32'(pctTable[i]), "port 2 percent");
            check(port1BoostPct, 32'(pctTable[7 - i]), "port 1 percent");
            xfer(1'b0, 12'h3e0, 32'h0);
            check(rdVal, {24'h0, 1'b0, 3'(i), 1'b0, 3'(7 - i)}, "boost readback");
        end
        for (int t = 0; t < 12; t++)
        begin
            r = rnd();
            xfer(1'b1, 12'h3e8, {24'h0, r[7:0]});
            xfer(1'b0, 12'h3e8, 32'h0);
            check(rdVal, {28'h0, r[3:0]}, "swap readback");
            xfer(1'b1, 12'h3c0, {31'h0, t[0]});
            eff = r[3:0] & {4{t[0]}};
            r = rnd();
            funcOut <= r[7:0];
            funcOeN <= r[15:8];
            pinIn <= r[23:16];
            repeat (4) @(posedge mclk);
            check(hubMode, 32'(t[0]), "hub mode");
            check(pinOut, swapLines(funcOut, eff), "pin drive");
            check(pinOeN, swapLines(funcOeN, eff), "pin enable");
            check(funcIn, swapLines(pinIn, eff), "received lines");
        end
        xfer(1'b1, 12'h3c0, 32'h3);
        for (int i = 0; i < 16; i++)
        begin
            l1 = logOf(i);
            l2 = logOf(15 - i);
            cnt = (l1 != 0) + (l2 != 0) + 1;
            xfer(1'b1, 12'h3ec, {24'h0, 4'(15 - i), 4'(i)});
            repeat (2) @(posedge mclk);
            check(port1Logical, 32'(l1), "port 1 logical");
            check(port2Logical, 32'(l2), "port 2 logical");
            check(reportedPortCount, 32'(cnt), "port count");
            xfer(1'b0, 12'h3c4, 32'h0);
            check(rdVal, 32'((cnt << 4) | (l2 << 2) | l1), "status");
            xfer(1'b0, 12'h3ec, 32'h0);
            check(rdVal, {24'h0, 4'(15 - i), 4'(i)}, "remap raw");
        end
        // a contiguous exchange of the two logical numbers, as software must keep them
        xfer(1'b1, 12'h3ec, 32'h12);
        repeat (2) @(posedge mclk);
        check({port2Logical, port1Logical, reportedPortCount}, 32'h1b, "contiguous exchange");
        xfer(1'b1, 12'h3c0, 32'h1);
        repeat (2) @(posedge mclk);
        check({remapEnable, port2Logical, port1Logical, reportedPortCount}, 32'h27, "remap off");
        xfer(1'b0, 12'h3f0, 32'h0);
        check(rdErr, 32'h1, "unmapped read error");
        check(rdVal, 32'h0, "unmapped read data");
        xfer(1'b1, 12'h3e1, 32'h77);
        check(rdErr, 32'h1, "unaligned write");
        xfer(1'b0, 12'h3e0, 32'h0);
        check(rdVal, 32'h70, "boost kept");
        stopTest();
    end
endmodule
